// ---- logic/crs_clock_request.sv ----
// Clock request output, pad-ring combining gate and reference selection.
`timescale 1ns/100ps
//
// Overview of operation
// - Assert the clock request while awake, deassert it while asleep.
// - Polarity strap 0 gives active-low request, 1 gives active-high.
// - While asleep, time from the low-power oscillator, external or internal.
// - OR mode only when mode select is tied high; second pin is input.
// - Without OR mode, output follows internal need; external input ignored.
// - Combining gate works whenever the I/O supply is present.
// - Strap 1: output is external input OR internal awake state.
// - Strap 0: output is external input AND NOT internal awake state.
// - External request is never inverted; source supplies matching polarity.
// - Unused clock request pin may serve its general-purpose functions.
// - Without a strap ball, strap is fixed; 42-ball package fixes it at 1.
// - Reference frequency defaults to 20 MHz.
// - Load reference frequency and trim from nonvolatile memory at reset.
// - Auto-detect standard frequency with stable 32.768 kHz external clock.
// - Serial and audio bit timing derive from the configured reference.
// - Trim the reference digitally to 2 ppm without changing loading.
// - Accept trim from host command or nonvolatile memory.
module crs_clock_request #(
	parameter bit STRAP_BONDED = 1'b1
) (
	// Clock and reset.
	input  wire logic             clk,
	input  wire logic             rst_n,
	// Power state and pad ring.
	input  wire logic             awake,
	input  wire logic             io_supply,
	// Straps.
	input  wire logic             request_polarity_strap,
	input  wire logic             or_mode_select,
	// Pin 5: clock request or general purpose output.
	input  wire logic             clk_req_enable,
	input  wire logic             gpio5_out,
	input  wire logic             gpio5_oe,
	output logic                  clk_req_pin_o,
	output logic                  clk_req_pin_oe,
	// Pin 6: external request input in OR mode.
	input  wire logic             ext_req_in,
	input  wire logic             gpio6_out,
	input  wire logic             gpio6_oe,
	output logic                  gpio6_pin_o,
	output logic                  gpio6_pin_oe,
	// Low-power clock sources.
	input  wire logic             lpo_external_sel,
	input  wire logic             lpo_ext_tick,
	input  wire logic             lpo_int_tick,
	input  wire logic             main_ref_tick,
	output logic                  timing_tick,
	// Power-on reset parameter load and detection.
	input  wire crs_pkg::crs_nv_t nv_params,
	input  wire logic             nv_done,
	input  wire logic             det_done,
	input  wire logic [11:0]      det_freq_10k,
	// Host trim command.
	input  wire logic             trim_wr,
	input  wire logic [15:0]      trim_wdata,
	// Configured reference.
	output logic [15:0]           ref_freq_khz,
	output logic [15:0]           ref_trim,
	output crs_pkg::crs_src_t     ref_source,
	output logic [15:0]           bit_timing_div,
	output logic                  config_ready
);

	crs_pkg::crs_regs_t r_q;
	crs_pkg::crs_regs_t r_d;
	logic               polarity;
	logic               internal_req;
	logic               or_active;
	logic               combined;
	logic               hit;
	logic [11:0]        hit_freq;

	// Match a measured frequency against the standard list.
	function automatic logic std_match(input logic [11:0] f,
	                                   input logic [11:0] s);
		logic [11:0] diff;
		diff = (f > s) ? f - s : s - f;
		return diff <= crs_pkg::DET_TOL_10K;
	endfunction

	// The 42-ball package has no strap ball, so the strap reads as 1.
	assign polarity = STRAP_BONDED ? request_polarity_strap : 1'b1;

	// The combining gate is pure logic in the always-on pad ring, so it does
	// not depend on the core clock or reset, only on the I/O supply.
	assign internal_req = awake;
	assign or_active = or_mode_select;

	always_comb begin
		if (!or_active) begin
			combined = polarity ? internal_req : ~internal_req;
		end else if (polarity) begin
			combined = ext_req_in | internal_req;
		end else begin
			combined = ext_req_in & ~internal_req;
		end
	end

	// Pin 5 is either the request output or a general-purpose pin.
	always_comb begin
		if (!io_supply) begin
			clk_req_pin_o  = 1'b0;
			clk_req_pin_oe = 1'b0;
		end else if (clk_req_enable || or_active) begin
			clk_req_pin_o  = combined;
			clk_req_pin_oe = 1'b1;
		end else begin
			clk_req_pin_o  = gpio5_out;
			clk_req_pin_oe = gpio5_oe;
		end
	end

	// Pin 6 becomes an input in OR mode; its level is never inverted.
	assign gpio6_pin_o  = gpio6_out;
	assign gpio6_pin_oe = io_supply & ~or_active & gpio6_oe;

	// Timing reference: main reference awake, low-power clock asleep.
	always_comb begin
		if (awake) begin
			timing_tick = main_ref_tick;
		end else if (lpo_external_sel) begin
			timing_tick = lpo_ext_tick;
		end else begin
			timing_tick = lpo_int_tick;
		end
	end

	// Standard-frequency search; detection accuracy is the board's duty.
	always_comb begin
		hit = 1'b0;
		hit_freq = 12'h000;
		for (int i = 0; i < crs_pkg::STD_COUNT; i++) begin
			if (!hit && std_match(det_freq_10k, crs_pkg::STD_FREQ_10K[i])) begin
				hit = 1'b1;
				hit_freq = crs_pkg::STD_FREQ_10K[i];
			end
		end
	end

	always_comb begin
		r_d = r_q;
		r_d.req_int = internal_req;
		case (r_q.state)
			crs_pkg::CRS_ST_LOAD: begin
				if (nv_done) begin
					if (nv_params.valid && nv_params.freq_present) begin
						r_d.freq_khz = nv_params.freq_khz;
						r_d.src = crs_pkg::CRS_SRC_NVRAM;
					end
					if (nv_params.valid && nv_params.trim_present) begin
						r_d.trim = nv_params.trim;
					end
					r_d.state = crs_pkg::CRS_ST_DETECT;
				end
			end
			crs_pkg::CRS_ST_DETECT: begin
				if (det_done) begin
					// Stored settings outrank detection.
					if (hit && r_q.src == crs_pkg::CRS_SRC_DEFAULT
					    && lpo_external_sel) begin
						r_d.freq_khz = 16'(hit_freq * 16'd10);
						r_d.src = crs_pkg::CRS_SRC_AUTO;
					end
					r_d.state = crs_pkg::CRS_ST_RUN;
				end
			end
			crs_pkg::CRS_ST_RUN: begin
				if (trim_wr) begin
					r_d.trim = trim_wdata;
				end
			end
			default: begin
				r_d.state = crs_pkg::CRS_ST_LOAD;
			end
		endcase
		// Bit-clock divider in MHz; serial and audio ports follow it.
		r_d.timing_div = 16'(r_d.freq_khz / 16'd1000);
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			r_q.state      <= crs_pkg::CRS_ST_LOAD;
			r_q.src        <= crs_pkg::CRS_SRC_DEFAULT;
			r_q.freq_khz   <= crs_pkg::REF_DEFAULT_KHZ;
			r_q.trim       <= crs_pkg::TRIM_DEFAULT;
			r_q.timing_div <= crs_pkg::TIMING_DIV_RST;
			r_q.req_int    <= 1'b0;
		end else begin
			r_q <= r_d;
		end
	end

	assign ref_freq_khz   = r_q.freq_khz;
	assign ref_trim       = r_q.trim;
	assign ref_source     = r_q.src;
	assign bit_timing_div = r_q.timing_div;
	assign config_ready   = (r_q.state == crs_pkg::CRS_ST_RUN);

	// Assertions.
	property p_or_high;
		@(posedge clk) disable iff (!rst_n)
		(io_supply && or_active && polarity)
			|-> clk_req_pin_o == (ext_req_in | awake);
	endproperty
	a_or_high: assert property (p_or_high) else $error("or high bad");

	property p_or_low;
		@(posedge clk) disable iff (!rst_n)
		(io_supply && or_active && !polarity)
			|-> clk_req_pin_o == (ext_req_in & ~awake);
	endproperty
	a_or_low: assert property (p_or_low) else $error("or low bad");

	property p_no_or;
		@(posedge clk) disable iff (!rst_n)
		(io_supply && !or_active && clk_req_enable)
			|-> clk_req_pin_o == (awake ~^ polarity);
	endproperty
	a_no_or: assert property (p_no_or) else $error("plain bad");

	property p_strap_fixed;
		@(posedge clk) disable iff (!rst_n)
		!STRAP_BONDED |-> polarity;
	endproperty
	a_strap_fixed: assert property (p_strap_fixed) else $error("strap");

	property p_default;
		@(posedge clk) disable iff (!rst_n)
		(r_q.src == crs_pkg::CRS_SRC_DEFAULT)
			|-> r_q.freq_khz == crs_pkg::REF_DEFAULT_KHZ;
	endproperty
	a_default: assert property (p_default) else $error("default");

	property p_hold;
		@(posedge clk) disable iff (!rst_n)
		(config_ready ##1 config_ready) |-> $stable(ref_freq_khz);
	endproperty
	a_hold: assert property (p_hold) else $error("freq moved");

	property p_trim;
		@(posedge clk) disable iff (!rst_n)
		(config_ready && trim_wr) |=> ref_trim == $past(trim_wdata);
	endproperty
	a_trim: assert property (p_trim) else $error("trim lost");

	property p_sleep_ref;
		@(posedge clk) disable iff (!rst_n)
		(!awake && !lpo_external_sel) |-> timing_tick == lpo_int_tick;
	endproperty
	a_sleep_ref: assert property (p_sleep_ref) else $error("sleep ref");

endmodule

// ---- logic/crs_pkg.sv ----
// Package with constants and carrier types for the clock request block.
package crs_pkg;

	// Reference frequency in kHz; 20 MHz default.
	localparam logic [15:0] REF_DEFAULT_KHZ = 16'h4E20;
	localparam int          STD_COUNT       = 17;
	// Standard reference frequencies in units of 10 kHz.
	localparam logic [11:0] STD_FREQ_10K [0:16] = '{
		12'h4B0, 12'h514, 12'h5A0, 12'h600, 12'h654, 12'h690, 12'h708,
		12'h780, 12'h798, 12'h7B0, 12'h7BC, 12'h7D0, 12'h960, 12'hA28,
		12'hD20, 12'hE9C, 12'hF00};
	// Low-power clock rate and detection tolerance.
	localparam int          LPO_HZ          = 32768;
	localparam logic [11:0] DET_TOL_10K     = 12'h001;
	// Tuning accuracy of the trim, in ppm.
	localparam int          TRIM_PPM        = 2;
	localparam logic [15:0] TRIM_DEFAULT    = 16'h0000;
	localparam logic [15:0] TIMING_DIV_RST  = 16'h0014;

	// Source of the reference frequency setting.
	typedef enum logic [1:0] {
		CRS_SRC_DEFAULT = 2'b00,
		CRS_SRC_AUTO    = 2'b01,
		CRS_SRC_NVRAM   = 2'b11
	} crs_src_t;

	// Startup state machine, Gray coded along the usual path.
	typedef enum logic [1:0] {
		CRS_ST_LOAD   = 2'b00,
		CRS_ST_DETECT = 2'b01,
		CRS_ST_RUN    = 2'b11
	} crs_state_t;

	// Parameters read from nonvolatile memory at power-on reset.
	typedef struct packed {
		logic        valid;
		logic        freq_present;
		logic [15:0] freq_khz;
		logic        trim_present;
		logic [15:0] trim;
	} crs_nv_t;

	// All state of the block.
	typedef struct packed {
		crs_state_t  state;
		crs_src_t    src;
		logic [15:0] freq_khz;
		logic [15:0] trim;
		logic [15:0] timing_div;
		logic        req_int;
	} crs_regs_t;

endpackage

// ---- testbench/crs_sys_req_model.sv ----
// Model of the system clock-request source and the reference clocks.
`timescale 1ns/100ps
module crs_sys_req_model (
	// Clock and request wish.
	input  wire logic clk,
	input  wire logic sys_need,
	input  wire logic polarity,
	// Pins toward the block.
	output logic      ext_req,
	output logic      lpo_tick,
	output logic      ref_tick
);
	// Always driven, already in the output polarity.
	assign ext_req = polarity ? sys_need : ~sys_need;
	// Ticks toggle in opposite phase so a wrong mux leg shows.
	initial begin
		lpo_tick = 1'b0;
		ref_tick = 1'b1;
	end
	always @(posedge clk) begin
		lpo_tick <= ~lpo_tick;
		ref_tick <= ~ref_tick;
	end
endmodule

// ---- testbench/test_crs_clock_request.sv ----
// Testbench for the clock request and reference selection block.
`timescale 1ns/100ps
module test_crs_clock_request;
	logic clk, rst_n, awake, io_sup, strap, orm, cre, g5o, g5oe;
	logic g6o, g6oe, sel, lint, nvd, detd, tw, need, ext, low_power_oscillator, mref;
	logic p5, p5oe, p6, p6oe, tick, rdy;
	logic [11:0] detf;
	logic [15:0] twd, rf, rt, div;
	crs_pkg::crs_nv_t nv;
	crs_pkg::crs_src_t rs;
	int mismatches = 0;
	int checked = 0;

	crs_sys_req_model i_crs_sys_req_model (.clk(clk), .sys_need(need),
		.polarity(strap), .ext_req(ext), .lpo_tick(low_power_oscillator), .ref_tick(mref));
	crs_clock_request i_crs_clock_request (.clk(clk), .rst_n(rst_n),
		.awake(awake), .io_supply(io_sup), .request_polarity_strap(strap),
		.or_mode_select(orm), .clk_req_enable(cre), .gpio5_out(g5o),
		.gpio5_oe(g5oe), .clk_req_pin_o(p5), .clk_req_pin_oe(p5oe),
		.ext_req_in(ext), .gpio6_out(g6o), .gpio6_oe(g6oe),
		.gpio6_pin_o(p6), .gpio6_pin_oe(p6oe), .lpo_external_sel(sel),
		.lpo_ext_tick(low_power_oscillator), .lpo_int_tick(lint), .main_ref_tick(mref),
		.timing_tick(tick), .nv_params(nv), .nv_done(nvd),
		.det_done(detd), .det_freq_10k(detf), .trim_wr(tw),
		.trim_wdata(twd), .ref_freq_khz(rf), .ref_trim(rt),
		.ref_source(rs), .bit_timing_div(div), .config_ready(rdy));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic c1(input logic got, input logic exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic c16(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic report_and_stop();
		$display("checked=%0d mismatches=%0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Every strap, mode, awake and external request combination.
	task automatic t_gate();
		for (int i = 0; i < 16; i++) begin
			@(posedge clk);
			orm <= i[3];
			strap <= i[2];
			awake <= i[1];
			need <= i[2] ? i[0] : ~i[0];
			@(negedge clk);
			if (i[3])
				c1(p5, i[2] ? (i[0] | i[1]) : (i[0] & ~i[1]));
			else
				c1(p5, i[2] ? i[1] : ~i[1]);
			c1(p5oe, 1'b1);
			c1(p6oe, ~i[3]);
		end
	endtask

	// Timing source follows the power state and low-power selection.
	task automatic t_timing();
		for (int i = 0; i < 8; i++) begin
			@(posedge clk);
			awake <= i[1];
			sel <= i[0];
			lint <= i[2];
			@(negedge clk);
			c1(tick, i[1] ? mref : (i[0] ? low_power_oscillator : i[2]));
		end
	endtask

	// Pin reuse, supply loss, and the gate while the core is in reset.
	task automatic t_pins();
		@(posedge clk);
		orm <= 1'b0;
		cre <= 1'b0;
		g5o <= 1'b1;
		@(negedge clk);
		c1(p5, 1'b1);
		@(posedge clk);
		g5o <= 1'b0;
		@(negedge clk);
		c1(p5, 1'b0);
		@(posedge clk);
		io_sup <= 1'b0;
		@(negedge clk);
		c1(p5oe, 1'b0);
		@(posedge clk);
		io_sup <= 1'b1;
		cre <= 1'b1;
		orm <= 1'b1;
		strap <= 1'b1;
		need <= 1'b1;
		awake <= 1'b0;
		rst_n <= 1'b0;
		@(negedge clk);
		c1(p5, 1'b1);
	endtask

	// Defaults, load, detection and host trims back to back.
	task automatic t_config();
		@(negedge clk);
		c16(rf, crs_pkg::REF_DEFAULT_KHZ);
		c16(div, 16'h0014);
		c1(rdy, 1'b0);
		@(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		nv <= '{1'b1, 1'b0, 16'h0000, 1'b1, 16'h0123};
		nvd <= 1'b1;
		sel <= 1'b1;
		@(posedge clk);
		nvd <= 1'b0;
		detd <= 1'b1;
		detf <= 12'h960;
		@(posedge clk);
		detd <= 1'b0;
		for (int n = 0; n < 5 && rdy !== 1'b1; n++)
			@(negedge clk);
		c1(rdy, 1'b1);
		c16(rt, 16'h0123);
		c16(rf, 16'h5DC0);
		c16({14'h0000, rs}, 16'h0001);
		c16(div, 16'h0018);
		@(posedge clk);
		tw <= 1'b1;
		twd <= 16'hFFF0;
		@(posedge clk);
		twd <= 16'h0042;
		@(posedge clk);
		tw <= 1'b0;
		repeat (2) @(negedge clk);
		c16(rt, 16'h0042);
		c16(rf, 16'h5DC0);
	endtask

	// Reset pulse of one clock edge in mid-run.
	task automatic pulse_reset();
		@(posedge clk);
		rst_n <= 1'b0;
		@(posedge clk);
		rst_n <= 1'b1;
	endtask

	// Stored frequency outranks detection; an early trim is refused.
	task automatic t_nvram();
		pulse_reset();
		@(negedge clk);
		c16(rt, crs_pkg::TRIM_DEFAULT);
		c16(rf, crs_pkg::REF_DEFAULT_KHZ);
		@(posedge clk);
		nv <= '{1'b1, 1'b1, 16'h4B00, 1'b0, 16'h0777};
		nvd <= 1'b1;
		tw <= 1'b1;
		twd <= 16'h0AAA;
		@(posedge clk);
		nvd <= 1'b0;
		tw <= 1'b0;
		detd <= 1'b1;
		detf <= 12'h960;
		@(posedge clk);
		detd <= 1'b0;
		@(negedge clk);
		c1(rdy, 1'b1);
		c16(rf, 16'h4B00);
		c16({14'h0000, rs}, 16'h0003);
		c16(rt, crs_pkg::TRIM_DEFAULT);
		c16(div, 16'h0013);
	endtask

	// Without the external low-power clock detection is ignored.
	task automatic t_nolpo();
		pulse_reset();
		@(posedge clk);
		nv <= '0;
		nvd <= 1'b1;
		sel <= 1'b0;
		@(posedge clk);
		nvd <= 1'b0;
		detd <= 1'b1;
		detf <= 12'h960;
		@(posedge clk);
		detd <= 1'b0;
		@(negedge clk);
		c1(rdy, 1'b1);
		c16(rf, crs_pkg::REF_DEFAULT_KHZ);
		c16({14'h0000, rs}, 16'h0000);
		c16(div, 16'h0014);
	endtask

	initial begin
		rst_n = 1'b0; awake = 1'b0; io_sup = 1'b1; strap = 1'b1;
		orm = 1'b0; cre = 1'b1; g5o = 1'b0; g5oe = 1'b1; g6o = 1'b0;
		g6oe = 1'b1; sel = 1'b0; lint = 1'b0; nvd = 1'b0; detd = 1'b0;
		tw = 1'b0; need = 1'b0; detf = 12'h000; twd = 16'h0000;
		nv = '0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		t_gate();
		t_timing();
		t_pins();
		t_config();
		t_nvram();
		t_nolpo();
		report_and_stop();
	end

	initial begin
		repeat (500) @(posedge clk);
		mismatches++;
		report_and_stop();
	end
endmodule
